// ### logic/sdrb_cfg_if.sv
// interface carrying configuration from the bus domain to the link engine
`timescale 1ns/1ps
interface sdrb_cfg_if;
  logic [1:0]  bl_mode;    // burst mode code
  logic        rpre_two;   // two-clock read preamble
  logic        dll_ok;     // dll enabled and locked
  logic [4:0]  add_lat;    // additive latency
  logic [4:0]  cas_lat;    // cas latency
  logic [31:0] data_base;  // data pattern base
  logic        rd_tgl;     // toggles once per read command taken
  logic [2:0]  eng_state;  // engine state code, link domain

  modport src (output bl_mode, rpre_two, dll_ok, add_lat, cas_lat, data_base,
               input rd_tgl, eng_state);
  modport eng (input bl_mode, rpre_two, dll_ok, add_lat, cas_lat, data_base,
               output rd_tgl, eng_state);
endinterface

// ### logic/sdrb_engine.sv
// link-clocked read engine: burst choice, latency, preamble, data, postamble
`timescale 1ns/1ps
module sdrb_engine (
  // link clock and reset
  input  wire logic  ck,
  input  wire logic  ck_rst_n,
  // command pins, already in the link domain
  input  wire logic  cmd_read,
  input  wire logic  addr_a10,
  input  wire logic  addr_a12,
  // configuration and status
  sdrb_cfg_if.eng    cfg,
  // data and strobe pins
  output logic [7:0] dq_o,
  output logic       dq_oe,
  output logic       dqs_o,
  output logic       dqs_oe,
  output logic       bank_open,
  output logic       pre_start
);

  // ************************************************************
  // configuration brought over from the bus domain
  // ************************************************************
  // quasi-static settings: two-flop each, changed only between bursts
  logic [45:0] cfg_s1_ff;
  logic [45:0] cfg_s2_ff;
  always_ff @(posedge ck) begin
    if (!ck_rst_n) begin
      cfg_s1_ff <= '0;
      cfg_s2_ff <= '0;
    end else begin
      cfg_s1_ff <= {cfg.bl_mode, cfg.rpre_two, cfg.dll_ok, cfg.add_lat,
                    cfg.cas_lat, cfg.data_base};
      cfg_s2_ff <= cfg_s1_ff;
    end
  end
  logic [1:0]  bl_mode;   // burst mode in use
  logic        rpre_two;  // preamble length select
  logic        dll_ok;    // lock gate
  logic [5:0]  rd_lat;    // read latency, al plus cl
  logic [31:0] dbase;     // data base
  assign {bl_mode, rpre_two, dll_ok} = cfg_s2_ff[45:42];
  assign rd_lat   = {1'b0, cfg_s2_ff[41:37]} + {1'b0, cfg_s2_ff[36:32]};  // [R12]
  assign dbase    = cfg_s2_ff[31:0];

  // ************************************************************
  // engine state
  // ************************************************************
  sdrb_pkg::sdrb_state_t state_ff;
  logic [5:0]  lat_cnt_ff;   // clocks since command
  logic [2:0]  beat_cnt_ff;  // clocks of data left
  logic        auto_pre_ff;  // precharge after the burst
  logic        rd_tgl_ff;    // read command event toggle
  logic [7:0]  dq_ff;
  logic        dq_oe_ff;
  logic        dqs_ff;
  logic        dqs_oe_ff;
  logic        open_ff;
  logic        pre_ff;

  // burst length chosen from mode and a12 at the command
  logic [2:0] nxt_len;
  always_comb begin
    unique case (bl_mode)
      sdrb_pkg::BL_FIX8: nxt_len = sdrb_pkg::DRIVE_BL8;                    // [R06] [R16]
      sdrb_pkg::BL_FIX4: nxt_len = sdrb_pkg::DRIVE_BC4;                    // [R07] [R16]
      sdrb_pkg::BL_OTF:  nxt_len = addr_a12 ? sdrb_pkg::DRIVE_BL8
                                            : sdrb_pkg::DRIVE_BC4;         // [R05]
      default:           nxt_len = sdrb_pkg::DRIVE_BL8;
    endcase
  end

  // preamble starts one or two clocks ahead of read latency
  logic [5:0] pre_at;
  assign pre_at = rd_lat - (rpre_two ? 6'h02 : 6'h01);  // [R14]

  // sequencer: a command is taken only while idle and locked
  always_ff @(posedge ck) begin
    if (!ck_rst_n) begin
      state_ff    <= sdrb_pkg::SDRB_IDLE;
      lat_cnt_ff  <= '0;
      beat_cnt_ff <= '0;
      auto_pre_ff <= 1'b0;
      rd_tgl_ff   <= 1'b0;
      open_ff     <= 1'b0;
      pre_ff      <= 1'b0;
    end else begin
      pre_ff <= 1'b0;
      unique case (state_ff)
        sdrb_pkg::SDRB_IDLE: begin
          if (cmd_read && dll_ok) begin                                    // [R13]
            state_ff    <= sdrb_pkg::SDRB_WAIT;
            lat_cnt_ff  <= 6'h01;
            beat_cnt_ff <= nxt_len;
            auto_pre_ff <= addr_a10;                                       // [R08] [R09]
            open_ff     <= 1'b1;
            rd_tgl_ff   <= ~rd_tgl_ff;
          end
        end
        sdrb_pkg::SDRB_WAIT: begin
          lat_cnt_ff <= lat_cnt_ff + 6'h01;
          if (lat_cnt_ff >= pre_at) begin
            state_ff <= sdrb_pkg::SDRB_PRE;
          end
        end
        sdrb_pkg::SDRB_PRE: begin
          lat_cnt_ff <= lat_cnt_ff + 6'h01;
          if (lat_cnt_ff >= rd_lat) begin                                  // [R10]
            state_ff <= sdrb_pkg::SDRB_DATA;
          end
        end
        sdrb_pkg::SDRB_DATA: begin
          beat_cnt_ff <= beat_cnt_ff - 3'h1;
          if (beat_cnt_ff == 3'h1) begin                                   // [R10] [R11]
            state_ff <= sdrb_pkg::SDRB_POST;
          end
        end
        sdrb_pkg::SDRB_POST: begin
          state_ff <= sdrb_pkg::SDRB_IDLE;
          if (auto_pre_ff) begin                                           // [R09]
            open_ff <= 1'b0;
            pre_ff  <= 1'b1;
          end
        end
      endcase
    end
  end

  // pin drive: strobe low in preamble, toggling data, one-clock postamble
  always_ff @(posedge ck) begin
    if (!ck_rst_n) begin
      dq_ff     <= '0;
      dq_oe_ff  <= 1'b0;
      dqs_ff    <= 1'b0;
      dqs_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff  <= (state_ff == sdrb_pkg::SDRB_PRE && lat_cnt_ff >= rd_lat)
                || (state_ff == sdrb_pkg::SDRB_DATA && beat_cnt_ff != 3'h1);  // [R10] [R11]
      dqs_oe_ff <= (state_ff == sdrb_pkg::SDRB_WAIT && lat_cnt_ff >= pre_at)
                || state_ff == sdrb_pkg::SDRB_PRE
                || state_ff == sdrb_pkg::SDRB_DATA;                           // [R14] [R15]
      dqs_ff    <= (state_ff == sdrb_pkg::SDRB_DATA || state_ff == sdrb_pkg::SDRB_PRE)
                && lat_cnt_ff >= rd_lat && beat_cnt_ff != 3'h1;               // [R15]
      dq_ff     <= dbase[7:0] ^ {5'h00, beat_cnt_ff};
    end
  end

  assign dq_o      = dq_ff;
  assign dq_oe     = dq_oe_ff;
  assign dqs_o     = dqs_ff;
  assign dqs_oe    = dqs_oe_ff;
  assign bank_open = open_ff;
  assign pre_start = pre_ff;
  assign cfg.rd_tgl    = rd_tgl_ff;
  assign cfg.eng_state = 3'(state_ff);

endmodule

// ### logic/sdrb_pkg.sv
// package of constants and types for the sdram read burst block
package sdrb_pkg;

  // ************************************************************
  // register map (byte offsets on the axi4-lite slave)
  // ************************************************************
  localparam logic [7:0] CFG_OFF    = 8'h00;  // burst mode, preamble, dll lock
  localparam logic [7:0] LAT_OFF    = 8'h04;  // additive and cas latency
  localparam logic [7:0] STAT_OFF   = 8'h08;  // live state of the read engine
  localparam logic [7:0] CNT_OFF    = 8'h0c;  // count of read commands taken
  localparam logic [7:0] DATA_OFF   = 8'h10;  // read data pattern base

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int          BLMODE_LSB  = 0;      // burst mode field, bits 1:0
  localparam int          RPRE_BIT    = 2;      // 1 = two-clock read preamble
  localparam int          DLL_BIT     = 3;      // 1 = dll enabled and locked
  localparam int          AL_LSB      = 0;      // additive latency, bits 4:0
  localparam int          CL_LSB      = 8;      // cas latency, bits 12:8
  localparam logic [31:0] CFG_RST     = 32'h0000_0008;
  localparam logic [31:0] LAT_RST     = 32'h0000_0b00;
  localparam logic [31:0] DATA_RST    = 32'h0000_0000;

  // ************************************************************
  // burst mode codes and burst lengths
  // ************************************************************
  localparam logic [1:0] BL_FIX8    = 2'h0;   // fixed eight-beat
  localparam logic [1:0] BL_OTF     = 2'h1;   // chosen per command by a12
  localparam logic [1:0] BL_FIX4    = 2'h2;   // fixed four-beat chop
  localparam logic [2:0] DRIVE_BL8  = 3'h4;   // clocks of data for eight beats
  localparam logic [2:0] DRIVE_BC4  = 3'h2;   // clocks of data for a chop

  // ************************************************************
  // bus response codes
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // read engine states
  typedef enum logic [2:0] {
    SDRB_IDLE,
    SDRB_WAIT,
    SDRB_PRE,
    SDRB_DATA,
    SDRB_POST
  } sdrb_state_t;

endpackage

// ### logic/sdrb_top.sv
// Behaviour
// R01: read to write spacing kept by controller
// R02: write to read spacing kept by controller
// R03: read burst counts eight or four
// R04: write burst counts eight unless fixed chop
// R05: on-the-fly a12 low chops, high eight
// R06: eight beats for mode 00 or 01+a12
// R07: four beats for mode 10 or 01+!a12
// R08: a10 low leaves the bank open
// R09: a10 high precharges after the burst
// R10: eight-beat data starts at rl, four clocks
// R11: chop releases data two clocks after rl
// R12: read latency is additive plus cas
// R13: reads served only with dll locked
// R14: preamble one or two clocks by select
// R15: half-clock postamble ends every burst (engine drives one clock of low strobe)
// R16: fixed modes ignore a12
`timescale 1ns/1ps
module sdrb_top (
  // bus clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link clock and command pins
  input  wire logic        ck,
  input  wire logic        ck_rst_n,
  input  wire logic        cmd_read,
  input  wire logic        addr_a10,
  input  wire logic        addr_a12,
  // data and strobe pins
  output logic [7:0]       dq_o,
  output logic             dq_oe,
  output logic             dqs_o,
  output logic             dqs_oe,
  output logic             bank_open,
  output logic             pre_start
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [31:0] cfg_ff;   // burst mode, preamble, dll lock
  logic [31:0] lat_ff;   // latencies
  logic [31:0] data_ff;  // data base
  logic [31:0] cnt_ff;   // read command count
  sdrb_cfg_if  cfg_bus ();

  assign cfg_bus.bl_mode   = cfg_ff[sdrb_pkg::BLMODE_LSB +: 2];
  assign cfg_bus.rpre_two  = cfg_ff[sdrb_pkg::RPRE_BIT];
  assign cfg_bus.dll_ok    = cfg_ff[sdrb_pkg::DLL_BIT];
  assign cfg_bus.add_lat   = lat_ff[sdrb_pkg::AL_LSB +: 5];
  assign cfg_bus.cas_lat   = lat_ff[sdrb_pkg::CL_LSB +: 5];
  assign cfg_bus.data_base = data_ff;

  // ************************************************************
  // link pins synchronised into the link domain, link reset used as given
  // ************************************************************
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  always_ff @(posedge ck) begin
    if (!ck_rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {cmd_read, addr_a10, addr_a12};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // read engine on the link clock
  sdrb_engine u_engine (
    .ck        (ck),
    .ck_rst_n  (ck_rst_n),
    .cmd_read  (pin_s2_ff[2]),
    .addr_a10  (pin_s2_ff[1]),
    .addr_a12  (pin_s2_ff[0]),
    .cfg       (cfg_bus.eng),
    .dq_o      (dq_o),
    .dq_oe     (dq_oe),
    .dqs_o     (dqs_o),
    .dqs_oe    (dqs_oe),
    .bank_open (bank_open),
    .pre_start (pre_start)
  );

  // ************************************************************
  // status crossing back to the bus clock
  // ************************************************************
  logic [3:0] st_s1_ff;
  logic [3:0] st_s2_ff;
  logic       tgl_d_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_s1_ff <= '0;
      st_s2_ff <= '0;
      tgl_d_ff <= 1'b0;
    end else if (ce) begin
      st_s1_ff <= {cfg_bus.rd_tgl, cfg_bus.eng_state};
      st_s2_ff <= st_s1_ff;
      tgl_d_ff <= st_s2_ff[3];
    end
  end

  // ************************************************************
  // axi4-lite write path
  // ************************************************************
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        do_write;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= sdrb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff == sdrb_pkg::CFG_OFF || awaddr_ff == sdrb_pkg::LAT_OFF
                   || awaddr_ff == sdrb_pkg::DATA_OFF) ? sdrb_pkg::RESP_OKAY
                                                       : sdrb_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // byte-lane merge of write data into the target register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction

  // configuration registers and read counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff  <= sdrb_pkg::CFG_RST;
      lat_ff  <= sdrb_pkg::LAT_RST;
      data_ff <= sdrb_pkg::DATA_RST;
      cnt_ff  <= '0;
    end else if (ce) begin
      if (do_write && awaddr_ff == sdrb_pkg::CFG_OFF)  cfg_ff  <= merge(cfg_ff, wdata_ff, wstrb_ff);
      if (do_write && awaddr_ff == sdrb_pkg::LAT_OFF)  lat_ff  <= merge(lat_ff, wdata_ff, wstrb_ff);
      if (do_write && awaddr_ff == sdrb_pkg::DATA_OFF) data_ff <= merge(data_ff, wdata_ff, wstrb_ff);
      if (st_s2_ff[3] != tgl_d_ff) cnt_ff <= cnt_ff + 32'h1;
    end
  end

  // ************************************************************
  // axi4-lite read path
  // ************************************************************
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= sdrb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= sdrb_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          sdrb_pkg::CFG_OFF:  rdata_ff <= cfg_ff;
          sdrb_pkg::LAT_OFF:  rdata_ff <= lat_ff;
          sdrb_pkg::STAT_OFF: rdata_ff <= {29'h0, st_s2_ff[2:0]};
          sdrb_pkg::CNT_OFF:  rdata_ff <= cnt_ff;
          sdrb_pkg::DATA_OFF: rdata_ff <= data_ff;
          default: begin
            rdata_ff <= '0;
            rresp_ff <= sdrb_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ready outputs registered: free while no answer pending
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
    end else if (ce) begin
      awready_ff <= !aw_got_ff && !(s_axi_awvalid && awready_ff) && !bvalid_ff && !do_write;
      wready_ff  <= !w_got_ff && !(s_axi_wvalid && wready_ff) && !bvalid_ff && !do_write;
      arready_ff <= !rvalid_ff && !(s_axi_arvalid && arready_ff);
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule

// ### verification/sdrb_chk_sva.sv
// checker for the read engine timing and the register bus handshake
`timescale 1ns/1ps
module sdrb_chk (
  // bus side
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // link side
  input wire logic        ck,
  input wire logic        ck_rst_n,
  input wire logic        dq_oe,
  input wire logic        dqs_o,
  input wire logic        dqs_oe,
  input wire logic        bank_open,
  input wire logic        pre_start
);
  // ************
  // helper count
  // ************
  logic [3:0] run_ff;   // clocks of the current data drive
  // data clock count
  always_ff @(posedge ck) begin
    if (!ck_rst_n) run_ff <= 4'h0;
    else run_ff <= dq_oe ? run_ff + 4'h1 : 4'h0;
  end
  // ************
  // properties
  // ************
  // data one or two clocks after strobe
  sequence s_pre;
    ##[1:2] $rose(dq_oe);
  endsequence
  // one clock of low strobe, then release
  sequence s_post;
    dqs_oe && !dqs_o ##1 !dqs_oe;
  endsequence
  property p_len;
    @(posedge ck) disable iff (!ck_rst_n) $fell(dq_oe) |-> run_ff == 4'h4 || run_ff == 4'h2;
  endproperty
  a_len: assert property (p_len) else $error("data drive length wrong");
  property p_lead;
    @(posedge ck) disable iff (!ck_rst_n) $rose(dqs_oe) |-> s_pre;
  endproperty
  a_lead: assert property (p_lead) else $error("preamble length wrong");
  property p_cover;
    @(posedge ck) disable iff (!ck_rst_n) $rose(dq_oe) |-> $past(dqs_oe);
  endproperty
  a_cover: assert property (p_cover) else $error("data before strobe");
  property p_post;
    @(posedge ck) disable iff (!ck_rst_n) $fell(dq_oe) |-> s_post;
  endproperty
  a_post: assert property (p_post) else $error("postamble wrong");
  property p_pulse;
    @(posedge ck) disable iff (!ck_rst_n) pre_start |=> !pre_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("precharge pulse too long");
  property p_close;
    @(posedge ck) disable iff (!ck_rst_n) pre_start |-> !dq_oe ##[0:1] !bank_open;
  endproperty
  a_close: assert property (p_close) else $error("precharge not after burst");
  property p_rans;
    @(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rhold;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule
bind sdrb_top sdrb_chk sdrb_chk_inst (.*);

// ### verification/sdrb_ctl_model.sv
// controller model: issues read commands and measures the returned burst
`timescale 1ns/1ps
module sdrb_ctl_model (
  // link clock
  input wire logic ck,
  // command pins
  output logic     cmd_read,
  output logic     addr_a10,
  output logic     addr_a12,
  // device outputs
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  input wire logic bank_open,
  input wire logic pre_start
);
  // command pins idle at time zero
  initial {cmd_read, addr_a10, addr_a12} = 3'h0;
  // one read then a watch span; reads far apart, no writes
  task automatic issue(input logic a10, a12, output int t_dqs, t_dq, n_dq, n_post, n_pre,
                       output logic open);
    t_dqs = -1;
    t_dq = -1;
    n_dq = 0;
    n_post = 0;
    n_pre = 0;
    repeat (4) @(posedge ck);
    cmd_read <= 1'b1;
    addr_a10 <= a10;
    addr_a12 <= a12;
    @(posedge ck);
    // command gone: show inverse address
    cmd_read <= 1'b0;
    addr_a10 <= ~a10;
    addr_a12 <= ~a12;
    for (int i = 1; i < 80; i++) begin
      @(posedge ck);
      if (dqs_oe && t_dqs < 0) t_dqs = i;
      if (dq_oe && t_dq < 0) t_dq = i;
      if (dq_oe) n_dq++;
      if (dqs_oe && !dq_oe && !dqs_o && t_dq >= 0) n_post++;
      if (pre_start) n_pre++;
    end
    open = bank_open;
  endtask
endmodule

// ### verification/tb_sdrb_read_burst_timing.sv
// self-checking bench for the read burst block
`timescale 1ns/1ps
module tb_sdrb_read_burst_timing;
  logic        aclk, aresetn, ck, ck_rst_n;        // clocks and resets
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dq_o;   // addresses, read data
  logic [31:0] s_axi_wdata, s_axi_rdata;           // bus data
  logic [1:0]  s_axi_bresp, s_axi_rresp;           // bus responses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cmd_read, addr_a10, addr_a12;
  logic        dq_oe, dqs_o, dqs_oe, bank_open, pre_start, open;
  int          n_errors, compares, t_dqs, t_dq, n_dq, n_post, n_pre;
  // device under test, clock enable held on
  sdrb_top sdrb_top_inst (.ce(1'b1), .s_axi_wstrb(4'hf), .*);
  // controller model on the link side
  sdrb_ctl_model sdrb_ctl_model_inst (.*);
  // bus clock, 100 ns
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // link clock, 64 ns, phase unrelated
  initial begin
    ck = 1'b0;
    #13;
    forever #32 ck = ~ck;
  end
  // ************
  // shared tasks
  // ************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one write, response compared with the expected code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  // one read, data and response handed back
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic go(input logic a10, input logic a12);
    sdrb_ctl_model_inst.issue(a10, a12, t_dqs, t_dq, n_dq, n_post, n_pre, open);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  // reset values, read-only and unmapped places
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  ad [5];
    logic [31:0] ex [5];
    ad = '{sdrb_pkg::CFG_OFF, sdrb_pkg::LAT_OFF, sdrb_pkg::STAT_OFF, sdrb_pkg::CNT_OFF,
           sdrb_pkg::DATA_OFF};
    ex = '{sdrb_pkg::CFG_RST, sdrb_pkg::LAT_RST, 32'h0, 32'h0, sdrb_pkg::DATA_RST};
    for (int i = 0; i < 5; i++) begin
      rd(ad[i], d, r);
      chk("reset_value", ex[i], d);
    end
    wr(sdrb_pkg::DATA_OFF, 32'h0000_00a5, sdrb_pkg::RESP_OKAY);
    rd(sdrb_pkg::DATA_OFF, d, r);
    chk("data_reg", 32'h0000_00a5, d);
    wr(sdrb_pkg::STAT_OFF, 32'h1, sdrb_pkg::RESP_SLVERR);
    wr(sdrb_pkg::CNT_OFF, 32'h1, sdrb_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, sdrb_pkg::RESP_SLVERR);
    rd(8'h14, d, r);
    chk("unmapped_rresp", 32'(sdrb_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped_rdata", 32'h0, d);
  endtask
  // all burst modes, a12 levels, preambles, auto precharge
  task automatic t_bursts();
    logic [1:0] m;
    logic       a10, a12, p2;
    logic [2:0] nb;
    for (int i = 0; i < 6; i++) begin
      m = (i < 2) ? sdrb_pkg::BL_FIX8 : (i < 4) ? sdrb_pkg::BL_OTF : sdrb_pkg::BL_FIX4;
      a12 = i[0];
      p2 = i[1];
      a10 = i[0] ^ i[1];
      wr(sdrb_pkg::CFG_OFF, {28'h0, 1'b1, p2, m}, sdrb_pkg::RESP_OKAY);
      go(a10, a12);
      // chop in fixed chop mode or on the fly with a12 low
      nb = (m == sdrb_pkg::BL_FIX4 || (m == sdrb_pkg::BL_OTF && !a12)) ?
           sdrb_pkg::DRIVE_BC4 : sdrb_pkg::DRIVE_BL8;
      chk("data_clocks", 32'(nb), 32'(n_dq));
      chk("preamble", p2 ? 32'h2 : 32'h1, 32'(t_dq - t_dqs));
      chk("postamble", 32'h1, 32'(n_post));
      chk("precharge", 32'(a10), 32'(n_pre));
      chk("bank_open", 32'(!a10), 32'(open));
    end
  endtask
  // first data moves with additive plus cas latency
  task automatic t_latency();
    int t0;
    wr(sdrb_pkg::CFG_OFF, 32'h8, sdrb_pkg::RESP_OKAY);
    go(1'b0, 1'b1);
    t0 = t_dq - 11; // pin and sync offset
    wr(sdrb_pkg::LAT_OFF, 32'h0000_0b0a, sdrb_pkg::RESP_OKAY);
    go(1'b0, 1'b1);
    chk("latency_21", 32'(t0 + 21), 32'(t_dq));
    wr(sdrb_pkg::LAT_OFF, 32'h0000_0300, sdrb_pkg::RESP_OKAY);
    go(1'b1, 1'b0);
    chk("latency_3", 32'(t0 + 3), 32'(t_dq));
  endtask
  // no burst while the dll is not locked
  task automatic t_dll();
    logic [31:0] c0, d;
    logic [1:0]  r;
    rd(sdrb_pkg::CNT_OFF, c0, r);
    chk("read_count", 32'h9, c0);
    wr(sdrb_pkg::CFG_OFF, 32'h0, sdrb_pkg::RESP_OKAY);
    go(1'b0, 1'b1);
    chk("unlocked_data", 32'h0, 32'(n_dq));
    wr(sdrb_pkg::CFG_OFF, 32'h8, sdrb_pkg::RESP_OKAY);
    go(1'b0, 1'b1);
    rd(sdrb_pkg::CNT_OFF, d, r);
    chk("locked_count", c0 + 32'h1, d);
    chk("locked_data", 32'h4, 32'(n_dq));
  endtask
  // reset in mid-run restores the configuration
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    wr(sdrb_pkg::CFG_OFF, 32'h5, sdrb_pkg::RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge ck);
    ck_rst_n <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge ck);
    ck_rst_n <= 1'b1;
    rd(sdrb_pkg::CFG_OFF, d, r);
    chk("cfg_after_reset", sdrb_pkg::CFG_RST, d);
  endtask
  // main sequence
  initial begin
    n_errors = 0;
    compares = 0;
    {aresetn, ck_rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge ck);
    ck_rst_n <= 1'b1;
    t_regs();
    t_bursts();
    t_latency();
    t_dll();
    t_reset();
    results();
  end
  // watchdog against a hang
  initial begin
    #2000000;
    n_errors++;
    results();
  end
endmodule
